/* File: hdl/vid_pin_route.sv */
// Voltage-ID pin routing and CPU selection
`timescale 1ns/1ps
module vid_pin_route (
  input  vlm_irq_pkg::vidPins_t   pins,
  input  wire logic [1:0]         route,
  input  wire logic [1:0]         cpuSel,
  output logic [4:0]              vid
);

  logic [4:0] cpu0Vid;
  logic [4:0] cpu1Vid;

  // Route bit 0 steers the first CPU, bit 1 the second
  assign cpu0Vid = route[0] ? pins.cpu0Alt : pins.cpu0Main;
  assign cpu1Vid = route[1] ? pins.cpu1Alt : pins.cpu1Main;

  always_comb begin
    unique case (cpuSel)
      vlm_irq_pkg::CPU_SEL_FIRST:  vid = cpu0Vid;
      vlm_irq_pkg::CPU_SEL_SECOND: vid = cpu1Vid;
      // Reserved codes give zero rather than a stale pin group
      default:                     vid = 5'h00;
    endcase
  end

endmodule : vid_pin_route

/* File: hdl/voltage_event_irq_routing.sv */
// Voltage event status, interrupt routing and voltage-ID readout registers
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module voltage_event_irq_routing (
  input  wire logic                 ref_clk,
  input  wire logic                 rst_n,
  input  wire logic                 ce,
  input  vlm_irq_pkg::regReq_t      req,
  output logic [7:0]                rdData,
  input  vlm_irq_pkg::vlmEvents_t   events,
  input  vlm_irq_pkg::vidPins_t     vidPins,
  output logic                      irq
);

  vlm_irq_pkg::regState_t st_r;
  vlm_irq_pkg::regState_t st_nxt;
  logic [4:0]             liveVid;
  logic [7:0]             readMux;
  logic [7:0]             pendLo;
  logic [5:0]             pendHi;
  logic [7:0]             statHiWide;

  function automatic logic hit(
    input vlm_irq_pkg::regReq_t r,
    input logic [7:0]           off
  );
    hit = (r.addr == off);
  endfunction : hit

  // Set beats clear so an event during the clearing read is kept
  function automatic logic [7:0] stickyNext(
    input logic [7:0] cur,
    input logic [7:0] setBits,
    input logic       clr
  );
    stickyNext = (clr ? 8'h00 : cur) | setBits;
  endfunction : stickyNext

  vid_pin_route routeSel (
    .pins   (vidPins),
    .route  (st_r.route),
    .cpuSel (st_r.cpuSel),
    .vid    (liveVid)
  );

  // Read view of every register
  always_comb begin
    readMux = 8'h00;
    if (hit(req, vlm_irq_pkg::OFF_STATUS_LO)) begin
      readMux = st_r.statLo;
    end else if (hit(req, vlm_irq_pkg::OFF_STATUS_HI)) begin
      readMux = {2'h0, st_r.statHi};
    end else if (hit(req, vlm_irq_pkg::OFF_IRQ_EN_LO)) begin
      readMux = st_r.enLo;
    end else if (hit(req, vlm_irq_pkg::OFF_IRQ_EN_HI)) begin
      // Reserved top bits never stored, so they read zero
      readMux = {2'h0, st_r.enHi};
    end else if (hit(req, vlm_irq_pkg::OFF_VID)) begin
      // Value bits are sampled live, no holding register
      readMux = {st_r.cpuSel, 1'b0, liveVid};
    end else if (hit(req, vlm_irq_pkg::OFF_VID_ROUTE)) begin
      readMux = {6'h00, st_r.route};
    end
  end

  always_comb begin
    st_nxt = st_r;
    // Status bits latch every event; a read of the register clears it
    st_nxt.statLo = stickyNext(st_r.statLo, events.lo,
                               req.rdEn && hit(req, vlm_irq_pkg::OFF_STATUS_LO));
    statHiWide    = stickyNext({2'h0, st_r.statHi}, {2'h0, events.hi},
                               req.rdEn && hit(req, vlm_irq_pkg::OFF_STATUS_HI));
    st_nxt.statHi = statHiWide[5:0];
    // Read data stands only in the cycle after the read strobe
    st_nxt.rdData = req.rdEn ? readMux : 8'h00;
    if (req.wrEn) begin
      if (hit(req, vlm_irq_pkg::OFF_IRQ_EN_LO)) begin
        st_nxt.enLo = req.wrData;
      end
      if (hit(req, vlm_irq_pkg::OFF_IRQ_EN_HI)) begin
        st_nxt.enHi = req.wrData[5:0];
      end
      if (hit(req, vlm_irq_pkg::OFF_VID)) begin
        // Only the select field is writable; reserved codes are stored as written
        st_nxt.cpuSel = req.wrData[7:6];
      end
      if (hit(req, vlm_irq_pkg::OFF_VID_ROUTE)) begin
        st_nxt.route = req.wrData[1:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.statLo <= vlm_irq_pkg::RST_STATUS_LO;
      st_r.statHi <= vlm_irq_pkg::RST_STATUS_HI;
      st_r.enLo   <= vlm_irq_pkg::RST_IRQ_EN_LO;
      st_r.enHi   <= vlm_irq_pkg::RST_IRQ_EN_HI;
      st_r.cpuSel <= vlm_irq_pkg::RST_CPU_SEL;
      st_r.route  <= vlm_irq_pkg::RST_ROUTE;
      st_r.rdData <= vlm_irq_pkg::RST_RD_DATA;
    end else if (ce) begin
      st_r <= st_nxt;
    end
  end

  assign pendLo = st_r.statLo & st_r.enLo;
  assign pendHi = st_r.statHi & st_r.enHi;
  assign irq    = (|pendLo) || (|pendHi);
  assign rdData = st_r.rdData;

  // Checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  standby_route_a: assert property (
    (ce && events.lo[vlm_irq_pkg::LO_STANDBY_BIT] && st_r.enLo[vlm_irq_pkg::LO_STANDBY_BIT])
    |=> irq)
    else $error("standby event with enable set did not raise interrupt");

  lo_enable_write_a: assert property (
    (ce && req.wrEn && req.addr == vlm_irq_pkg::OFF_IRQ_EN_LO)
    |=> (st_r.enLo == $past(req.wrData)) ##1 (!$past(ce) || !$past(req.wrEn)
        || $past(req.addr) != vlm_irq_pkg::OFF_IRQ_EN_LO
        || st_r.enLo == $past(req.wrData)))
    else $error("low enable register did not take written value");

  hi_reserved_read_a: assert property (
    (ce && req.rdEn && req.addr == vlm_irq_pkg::OFF_IRQ_EN_HI)
    |=> (rdData[7:6] == 2'h0) && (rdData[5:0] == $past(st_r.enHi)))
    else $error("high enable readback wrong or reserved bits set");

  battery_route_a: assert property (
    (ce && events.hi[vlm_irq_pkg::HI_BATTERY_BIT] && st_r.enHi[vlm_irq_pkg::HI_BATTERY_BIT])
    |=> irq ##1 (irq || $past(ce)))
    else $error("battery event with enable set did not raise interrupt");

  masked_quiet_a: assert property (
    (st_r.enLo == 8'h00 && st_r.enHi == 6'h00) |-> !irq)
    else $error("interrupt raised with every enable cleared");

  cpu_select_a: assert property (
    (ce && req.wrEn && req.addr == vlm_irq_pkg::OFF_VID)
    |=> st_r.cpuSel == $past(req.wrData[7:6]))
    else $error("CPU select field did not take written value");

  vid_live_a: assert property (
    (ce && req.rdEn && req.addr == vlm_irq_pkg::OFF_VID
     && st_r.cpuSel == vlm_irq_pkg::CPU_SEL_SECOND && !st_r.route[1])
    |=> (rdData[4:0] == $past(vidPins.cpu1Main)) && !rdData[vlm_irq_pkg::VID_RSVD_BIT])
    else $error("voltage-ID readout does not match selected CPU pins");

  vid_route_a: assert property (
    (ce && req.rdEn && req.addr == vlm_irq_pkg::OFF_VID
     && st_r.cpuSel == vlm_irq_pkg::CPU_SEL_FIRST && st_r.route[0])
    |=> rdData[4:0] == $past(vidPins.cpu0Alt))
    else $error("route select did not steer alternate pins");

  status_sticky_a: assert property (
    (ce && events.hi[vlm_irq_pkg::HI_TEMP1_BIT])
    |=> st_r.statHi[vlm_irq_pkg::HI_TEMP1_BIT])
    else $error("temperature event did not set its status bit");

  status_clear_a: assert property (
    (ce && req.rdEn && req.addr == vlm_irq_pkg::OFF_STATUS_LO && events.lo == 8'h00)
    |=> st_r.statLo == 8'h00 && rdData == $past(st_r.statLo))
    else $error("status read did not report and clear");

  read_window_a: assert property (
    (ce && !req.rdEn) |=> rdData == 8'h00)
    else $error("read data present without a read strobe");

  irq_rise_c: cover property (!irq ##1 irq);
  second_cpu_c: cover property (
    ce && req.rdEn && req.addr == vlm_irq_pkg::OFF_VID
    && st_r.cpuSel == vlm_irq_pkg::CPU_SEL_SECOND);
  clear_race_c: cover property (
    ce && req.rdEn && req.addr == vlm_irq_pkg::OFF_STATUS_LO && events.lo != 8'h00);
  temp_irq_c: cover property (irq && pendHi[vlm_irq_pkg::HI_TEMP3_BIT]);

endmodule : voltage_event_irq_routing

/* File: pkg/vlm_irq_pkg.sv */
// Package of constants and carrier types for the voltage event routing registers
//
// Notes on behaviour
// - Bit 7 of low enable register routes standby supply event to interrupt; resets zero.
// - Bits 6..0 of low enable register route analog voltage inputs six..zero; reset zero.
// - High enable bits 5..3 route temperature channels three..one; bits 7..6 read zero.
// - High enable bits 2,1,0 route analog supply, battery and core supply events; reset zero.
// - Voltage-ID bits 7..6 select CPU: 00 first (reset), 01 second, others reserved.
// - Voltage-ID bits 4..0 read live selected CPU inputs; bit 5 reads zero.
// - Pins feeding the voltage-ID value come from a separate route-select register.
// - Status bits read one after a limit or over-temperature event; they feed routing.
package vlm_irq_pkg;

  // Register offsets
  localparam logic [7:0] OFF_STATUS_LO  = 8'h00;
  localparam logic [7:0] OFF_STATUS_HI  = 8'h01;
  localparam logic [7:0] OFF_IRQ_EN_LO  = 8'h04;
  localparam logic [7:0] OFF_IRQ_EN_HI  = 8'h05;
  localparam logic [7:0] OFF_VID        = 8'h06;
  localparam logic [7:0] OFF_VID_ROUTE  = 8'h08;

  // Field positions
  localparam int LO_STANDBY_BIT   = 7;
  localparam int HI_TEMP3_BIT     = 5;
  localparam int HI_TEMP2_BIT     = 4;
  localparam int HI_TEMP1_BIT     = 3;
  localparam int HI_ASUPPLY_BIT   = 2;
  localparam int HI_BATTERY_BIT   = 1;
  localparam int HI_CORE_BIT      = 0;
  localparam int HI_WIDTH         = 6;
  localparam int VID_WIDTH        = 5;
  localparam int VID_SEL_LSB      = 6;
  localparam int VID_RSVD_BIT     = 5;

  // Field codes
  localparam logic [1:0] CPU_SEL_FIRST  = 2'h0;
  localparam logic [1:0] CPU_SEL_SECOND = 2'h1;

  // Reset values
  localparam logic [7:0] RST_IRQ_EN_LO  = 8'h00;
  localparam logic [5:0] RST_IRQ_EN_HI  = 6'h00;
  localparam logic [7:0] RST_STATUS_LO  = 8'h00;
  localparam logic [5:0] RST_STATUS_HI  = 6'h00;
  localparam logic [1:0] RST_CPU_SEL    = 2'h0;
  localparam logic [1:0] RST_ROUTE      = 2'h0;
  localparam logic [7:0] RST_RD_DATA    = 8'h00;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wrData;
    logic       wrEn;
    logic       rdEn;
  } regReq_t;

  // Event sources from the level monitor, one pulse or level per channel
  typedef struct packed {
    logic [7:0] lo;
    logic [5:0] hi;
  } vlmEvents_t;

  // Candidate voltage-ID pin groups, main and alternate per CPU
  typedef struct packed {
    logic [4:0] cpu0Main;
    logic [4:0] cpu0Alt;
    logic [4:0] cpu1Main;
    logic [4:0] cpu1Alt;
  } vidPins_t;

  // Whole register state of the block
  typedef struct packed {
    logic [7:0] statLo;
    logic [5:0] statHi;
    logic [7:0] enLo;
    logic [5:0] enHi;
    logic [1:0] cpuSel;
    logic [1:0] route;
    logic [7:0] rdData;
  } regState_t;

endpackage : vlm_irq_pkg

/* File: sim/voltage_event_irq_routing_tb.sv */
// Self-checking bench for the voltage event routing registers
`timescale 1ns/1ps
module voltage_event_irq_routing_tb;
  logic                    clk;
  logic                    rst_n;
  logic                    ce;
  vlm_irq_pkg::regReq_t    req;
  vlm_irq_pkg::vlmEvents_t events;
  vlm_irq_pkg::vidPins_t   pins;
  logic [7:0]              rdData;
  logic                    irq;
  int                      miscompares;
  int                      checked;

  voltage_event_irq_routing voltage_event_irq_routing_i (
    .ref_clk(clk), .rst_n(rst_n), .ce(ce), .req(req), .rdData(rdData),
    .events(events), .vidPins(pins), .irq(irq)
  );

  always #50 clk = ~clk;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{addr: a, wrData: d, wrEn: 1'b1, rdEn: 1'b0};
    @(posedge clk);
    req <= '0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rdChk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    req <= '{addr: a, wrData: 8'h00, wrEn: 1'b0, rdEn: 1'b1};
    @(posedge clk);
    req <= '0;
    #1 chk(rdData, exp);
  endtask : rdChk

  task automatic test_reset;
    rdChk(8'h04, 8'h00);
    rdChk(8'h05, 8'h00);
    rdChk(8'h06, {3'h0, pins.cpu0Main});
    chk({7'h0, irq}, 8'h00);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_enables;
    wr(8'h04, 8'hff);
    wr(8'h05, 8'hff);
    rdChk(8'h04, 8'hff);
    rdChk(8'h05, 8'h3f);
    wr(8'h04, 8'h81);
    wr(8'h05, 8'h05);
    rdChk(8'h04, 8'h81);
    rdChk(8'h05, 8'h05);
    wr(8'h0a, 8'h5a);
    rdChk(8'h0a, 8'h00);
    wr(8'h00, 8'hff);
    rdChk(8'h00, 8'h00);
    $display("test_enables done");
  endtask : test_enables

  task automatic test_vid;
    wr(8'h06, 8'h7f);
    rdChk(8'h06, {3'h2, pins.cpu1Main});
    @(posedge clk);
    pins.cpu1Main <= 5'h13;
    rdChk(8'h06, 8'h53);
    wr(8'h08, 8'h03);
    rdChk(8'h06, {3'h2, pins.cpu1Alt});
    wr(8'h08, 8'h00);
    wr(8'h06, 8'hc0);
    rdChk(8'h06, 8'hc0);
    wr(8'h06, 8'h00);
    rdChk(8'h06, {3'h0, pins.cpu0Main});
    $display("test_vid done");
  endtask : test_vid

  // Every source once masked and once routed
  task automatic test_irq;
    logic [13:0] m;
    for (int i = 0; i < 14; i++) begin
      for (int en = 0; en < 2; en++) begin
        m = 14'h1 << i;
        wr(8'h04, (en == 1) ? m[13:6] : 8'h00);
        wr(8'h05, (en == 1) ? {2'h0, m[5:0]} : 8'h00);
        @(posedge clk);
        events <= vlm_irq_pkg::vlmEvents_t'(m);
        @(posedge clk);
        events <= '0;
        #1 chk({7'h0, irq}, (en == 1) ? 8'h01 : 8'h00);
        if (i >= 6) rdChk(8'h00, m[13:6]);
        else rdChk(8'h01, {2'h0, m[5:0]});
        chk({7'h0, irq}, 8'h00);
      end
    end
    $display("test_irq done");
  endtask : test_irq

  // A write while the clock enable is low must leave the register untouched
  task automatic test_freeze;
    wr(8'h04, 8'h11);
    @(posedge clk);
    ce  <= 1'b0;
    req <= '{addr: 8'h04, wrData: 8'hee, wrEn: 1'b1, rdEn: 1'b0};
    @(posedge clk);
    ce  <= 1'b1;
    req <= '0;
    rdChk(8'h04, 8'h11);
    $display("test_freeze done");
  endtask : test_freeze

  task automatic test_done;
    $display("checks %0d, mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : test_done

  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    req = '0;
    events = '0;
    pins = {5'h0b, 5'h14, 5'h19, 5'h06};
    miscompares = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    test_reset;
    test_enables;
    test_vid;
    test_irq;
    test_freeze;
    test_done;
  end

  // About 285 cycles expected; 20000 cycles leaves ample margin
  initial begin
    #2_000_000;
    miscompares++;
    test_done;
  end
endmodule : voltage_event_irq_routing_tb
